// file: usb_periph_irq_output.sv
/*
 * Interrupt output logic: status and reason registers, enables, global gate,
 * pipe event qualification, and the level or pulse interrupt pin.
 * Assumes a processor on a separate 8-bit address and 16-bit data bus with
 * active-low chip select, read and write strobes from outside the clock domain,
 * and event pulses from logic on the same clock.
 */
`timescale 1ns/1ps
`include "usb_irq_cfg.svh"
`default_nettype none

module usb_periph_irq_output
    import usb_irq_pkg::*;
#(
    parameter int DATA_W = 16
) (
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Processor bus pins.
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [7:0]        addr,
    input  wire logic [DATA_W-1:0] data_in,
    output var  logic [DATA_W-1:0] data_out,
    output var  logic              data_oe,
    // Event pulses from the core.
    input  wire logic [DATA_W-1:0] usb_event,
    input  wire logic [DATA_W-1:0] dma_event,
    input  wire logic [2:0]        pipe_ack,
    input  wire logic [2:0]        pipe_nak,
    // Pins toward the host.
    output var  logic              irq_pin,
    output var  logic              suspend_ind
);
    // Pin synchronisers, two stages each.
    logic              cs_n_s1_reg, cs_n_s2_reg, rd_n_s1_reg, rd_n_s2_reg;
    logic              wr_n_s1_reg, wr_n_s2_reg, wr_n_last_reg;
    logic [7:0]        addr_s1_reg, addr_s2_reg;
    logic [DATA_W-1:0] wdata_s1_reg, wdata_s2_reg;
    // Registers.
    logic [15:0]       mode_reg;
    logic [7:0]        cfg_reg;
    logic [DATA_W-1:0] irq_en_reg, irq_status_reg, dma_reason_reg, dma_en_reg;
    logic [2:0]        nak_seen_reg;
    logic              pending_last_reg, level_active_reg;
    logic [3:0]        pulse_cnt_reg;

    // Strobe synchronisers; they reset to the idle high level so no false edge follows reset.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            rd_n_s1_reg <= 1'b1;
            rd_n_s2_reg <= 1'b1;
            wr_n_s1_reg <= 1'b1;
            wr_n_s2_reg <= 1'b1;
        end else begin
            cs_n_s1_reg <= cs_n;
            cs_n_s2_reg <= cs_n_s1_reg;
            rd_n_s1_reg <= rd_n;
            rd_n_s2_reg <= rd_n_s1_reg;
            wr_n_s1_reg <= wr_n;
            wr_n_s2_reg <= wr_n_s1_reg;
        end
    end

    // Address and data synchronisers; a word is only used once the synced strobe
    // shows it has stood still for several cycles, so a skewed bit is never taken.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_s1_reg  <= 8'h00;
            addr_s2_reg  <= 8'h00;
            wdata_s1_reg <= '0;
            wdata_s2_reg <= '0;
        end else begin
            addr_s1_reg  <= addr;
            addr_s2_reg  <= addr_s1_reg;
            wdata_s1_reg <= data_in;
            wdata_s2_reg <= wdata_s1_reg;
        end
    end

    // Address decode; a write is taken when the synced write strobe rises.
    wire logic wr_take  = !wr_n_last_reg && wr_n_s2_reg && !cs_n_s2_reg;
    wire logic rd_act   = !rd_n_s2_reg && !cs_n_s2_reg;
    wire logic sel_mode = addr_s2_reg == `OFS_MODE;
    wire logic sel_cfg  = addr_s2_reg == `OFS_IRQ_CFG;
    wire logic sel_ien  = addr_s2_reg == `OFS_IRQ_ENABLE;
    wire logic sel_ist  = addr_s2_reg == `OFS_IRQ_STATUS;
    wire logic sel_drs  = addr_s2_reg == `OFS_DMA_REASON;
    wire logic sel_den  = addr_s2_reg == `OFS_DMA_ENABLE;

    // Read mux; unmapped offsets read zero.
    wire logic [DATA_W-1:0] rd_mux =
        sel_mode ? mode_reg :
        sel_cfg  ? {8'h00, cfg_reg} :
        sel_ien  ? irq_en_reg :
        sel_ist  ? irq_status_reg :
        sel_drs  ? dma_reason_reg :
        sel_den  ? dma_en_reg : `WORD_ZERO;

    // Pipe mode fields from the configuration register.
    wire pipe_mode_type mode_ctrl = pipe_mode_type'(cfg_reg[`CFG_CTRL_LSB +: 2]);
    wire pipe_mode_type mode_in   = pipe_mode_type'(cfg_reg[`CFG_IN_LSB +: 2]);
    wire pipe_mode_type mode_out  = pipe_mode_type'(cfg_reg[`CFG_OUT_LSB +: 2]);

    // Decides whether a pipe's ACK or NAK raises its status bit.
    function automatic logic pipe_raise(input pipe_mode_type m, input logic ack,
                                        input logic nak, input logic seen);
        case (m)
            PIPE_ACK_ONLY:  pipe_raise = ack;
            PIPE_FIRST_NAK: pipe_raise = ack || (nak && !seen);
            PIPE_ALL_NAK:   pipe_raise = ack || nak;
            default:        pipe_raise = ack;
        endcase
    endfunction

    wire logic [2:0] pipe_hit = {pipe_raise(mode_out, pipe_ack[2], pipe_nak[2], nak_seen_reg[2]),
                                 pipe_raise(mode_in, pipe_ack[1], pipe_nak[1], nak_seen_reg[1]),
                                 pipe_raise(mode_ctrl, pipe_ack[0], pipe_nak[0], nak_seen_reg[0])};
    // Low three status bits belong to the control, IN and OUT pipes.
    wire logic [DATA_W-1:0] usb_set = {usb_event[DATA_W-1:3], pipe_hit};
    // Write one to clear; a new event in the same cycle wins.
    wire logic [DATA_W-1:0] ist_clr = (wr_take && sel_ist) ? wdata_s2_reg : '0;
    wire logic [DATA_W-1:0] drs_clr = (wr_take && sel_drs) ? wdata_s2_reg : '0;
    wire logic [DATA_W-1:0] ist_next = (irq_status_reg & ~ist_clr) | usb_set;
    wire logic [DATA_W-1:0] drs_next = (dma_reason_reg & ~drs_clr) | dma_event;

    // Enabled pending events and the global gate.
    wire logic pending = |(irq_status_reg & irq_en_reg) | |(dma_reason_reg & dma_en_reg);
    wire logic gate    = mode_reg[`MODE_GATE_BIT];
    wire logic form_pulse = cfg_reg[`CFG_FORM_BIT];
    wire logic pol_high   = cfg_reg[`CFG_POL_BIT];
    // Level stays set once raised until nothing is pending, even if the gate closes.
    wire logic level_next = pending && (gate || level_active_reg);
    wire logic pulse_start = pending && !pending_last_reg && gate;
    wire logic [3:0] pulse_next = pulse_start ? 4'(`PULSE_CYCLES) :
                                  (pulse_cnt_reg != 4'h0) ? pulse_cnt_reg - 4'h1 : 4'h0;
    wire logic active_next = form_pulse ? (pulse_next != 4'h0) : level_next;
    // Selected polarity applies to both forms; inactive level otherwise.
    wire logic pin_next = active_next ? pol_high : !pol_high;

    // Bus-written registers; a write lands one edge after the synced strobe rises.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_n_last_reg <= 1'b1;
            mode_reg      <= `MODE_RESET;
            cfg_reg       <= `CFG_RESET;
            irq_en_reg    <= '0;
            dma_en_reg    <= '0;
        end else begin
            wr_n_last_reg <= wr_n_s2_reg;
            if (wr_take && sel_mode) begin
                mode_reg <= wdata_s2_reg;
            end
            if (wr_take && sel_cfg) begin
                cfg_reg <= wdata_s2_reg[7:0];
            end
            if (wr_take && sel_ien) begin
                irq_en_reg <= wdata_s2_reg;
            end
            if (wr_take && sel_den) begin
                dma_en_reg <= wdata_s2_reg;
            end
        end
    end

    // Event logging; the NAK memory is re-armed by an ACK on the same pipe.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_status_reg <= '0;
            dma_reason_reg <= '0;
            nak_seen_reg   <= 3'b000;
        end else begin
            irq_status_reg <= ist_next;
            dma_reason_reg <= drs_next;
            nak_seen_reg   <= (nak_seen_reg | pipe_nak) & ~pipe_ack;
        end
    end

    // Pin state; the pin resets high, which is the inactive level of the default
    // active-low polarity, so the host sees no request while the core starts.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_last_reg <= 1'b0;
            level_active_reg <= 1'b0;
            pulse_cnt_reg    <= 4'h0;
            irq_pin          <= 1'b1;
            suspend_ind      <= 1'b0;
        end else begin
            pending_last_reg <= pending && gate;
            level_active_reg <= level_next;
            pulse_cnt_reg    <= pulse_next;
            irq_pin          <= pin_next;
            suspend_ind      <= 1'b0;
        end
    end

    // Read port; data follows the synced address so it has settled while the strobe is low.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= '0;
            data_oe  <= 1'b0;
        end else begin
            data_out <= rd_mux;
            data_oe  <= rd_act;
        end
    end
endmodule
`default_nettype wire

// file: usb_irq_cfg.svh
/*
 * Offsets, field positions, reset values and timing for the interrupt output block.
 * Assumes it is included by bare name from the design file and the testbench.
 */
`ifndef USB_IRQ_CFG_SVH
`define USB_IRQ_CFG_SVH

// Register offsets on the 8-bit processor address bus.
`define OFS_MODE        8'h0C
`define OFS_IRQ_CFG     8'h10
`define OFS_IRQ_ENABLE  8'h14
`define OFS_IRQ_STATUS  8'h18
`define OFS_DMA_REASON  8'h50
`define OFS_DMA_ENABLE  8'h54

// Field positions in the mode and interrupt configuration registers.
`define MODE_GATE_BIT   3
`define CFG_POL_BIT     0
`define CFG_FORM_BIT    1
`define CFG_OUT_LSB     2
`define CFG_IN_LSB      4
`define CFG_CTRL_LSB    6

// Reset values: active-low polarity, level form, gate closed.
`define MODE_RESET      16'h0000
`define CFG_RESET       8'h00
`define WORD_ZERO       16'h0000

// Pulse length in ns and core clock period in ns.
`define PULSE_NS        60
`define CLK_PERIOD_NS   50
`define PULSE_CYCLES    ((`PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: usb_irq_pkg.sv
/*
 * Types shared by the interrupt output block.
 * Assumes the constants header sits in the same folder.
 */
`default_nettype none
package usb_irq_pkg;
    // Condition under which a pipe raises its status bit.
    typedef enum logic [1:0] {
        PIPE_ACK_ONLY  = 2'b00,
        PIPE_FIRST_NAK = 2'b01,
        PIPE_ALL_NAK   = 2'b10,
        PIPE_RESERVED  = 2'b11
    } pipe_mode_type;
endpackage
`default_nettype wire

// file: usb_periph_irq_output_asserts.sv
/* Port checker for the interrupt output block.
   Assumes one core clock and the active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module usb_periph_irq_output_asserts (
    // Watched ports.
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        wr_n,
    input wire logic [7:0]  addr,
    input wire logic [15:0] data_out,
    input wire logic        data_oe,
    input wire logic [15:0] usb_event,
    input wire logic [15:0] dma_event,
    input wire logic [2:0]  pipe_ack,
    input wire logic [2:0]  pipe_nak,
    input wire logic        irq_pin,
    input wire logic        suspend_ind
);
    logic [3:0] quiet_reg;
    // Counts cycles since the last event pulse or write strobe.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            quiet_reg <= 4'h0;
        end else if ((|{usb_event, dma_event, pipe_ack, pipe_nak}) || !wr_n) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_suspend_held: assert property (suspend_ind == 1'b0)
        else $error("suspend indicator went high");
    a_pin_after_reset: assert property (!$past(arst_n) |-> irq_pin)
        else $error("pin not high just after reset");
    a_pulse_min_width: assert property ($changed(irq_pin) |=> $stable(irq_pin))
        else $error("pin level lasted one cycle");
    a_pin_quiet: assert property (quiet_reg > 4'h8 |-> $stable(irq_pin))
        else $error("pin moved with no cause");
    a_read_drives: assert property ((!cs_n && !rd_n) [*5] |-> data_oe)
        else $error("read not driving data bus");
    a_idle_release: assert property (rd_n [*5] |-> !data_oe)
        else $error("data bus driven while idle");
    a_oe_needs_read: assert property (data_oe |->
        !$past(rd_n, 2) || !$past(rd_n, 3) || !$past(rd_n, 4))
        else $error("data bus driven without read");
    a_unmapped_zero: assert property ((addr == 8'h20) [*5] |-> data_out == 16'h0000)
        else $error("unmapped address read nonzero");
endmodule
bind usb_periph_irq_output usb_periph_irq_output_asserts u_chk (.*);
`default_nettype wire

// file: host_irq_watch.sv
/* Host model that counts interrupt requests seen on the pin.
   Assumes the bench tells it which pin level is active. */
`timescale 1ns/1ps
`default_nettype none
module host_irq_watch (
    // Clock, pin and active level.
    input  wire logic clk,
    input  wire logic irq_pin,
    input  wire logic active_high,
    // Number of request onsets seen.
    output var  int   irq_seen
);
    bit was_active;
    // Counts each move of the pin into its active level.
    always @(posedge clk) begin
        if ((irq_pin === active_high) && !was_active) begin
            irq_seen <= irq_seen + 1;
        end
        was_active <= (irq_pin === active_high);
    end
endmodule
`default_nettype wire

// file: tb_usb_periph_irq_output.sv
/* Testbench for the interrupt output block.
   Assumes the design, header, checker and host model are compiled first. */
`timescale 1ns/1ps
`include "usb_irq_cfg.svh"
`default_nettype none
module tb_usb_periph_irq_output;
    // Bus, event and pin signals.
    logic        clk = 1'b0, arst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic        act_hi = 1'b0, data_oe, irq_pin, suspend_ind;
    logic [7:0]  addr = 8'h00;
    logic [2:0]  pipe_ack = 3'h0, pipe_nak = 3'h0;
    logic [15:0] data_in = 16'h0000, usb_event = 16'h0000, dma_event = 16'h0000;
    logic [15:0] data_out, rd_data;
    int          fail_count = 0, checks_done = 0, irq_seen, seen, hi_n;
    // Core clock and the two partners.
    always #25 clk = ~clk;
    usb_periph_irq_output u_dut (.*);
    host_irq_watch u_host (.clk(clk), .irq_pin(irq_pin), .active_high(act_hi),
                           .irq_seen(irq_seen));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pin(input logic e);
        chk({15'h0, irq_pin}, {15'h0, e});
    endtask
    // Strobe edges are spaced for the two-flop pin synchroniser.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        data_in = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        cyc(4);
        wr_n = 1'b1;
        cyc(4);
        cs_n = 1'b1;
        cyc(3);
    endtask
    task automatic rd(input logic [7:0] a);
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        cyc(6);
        rd_data = data_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        cyc(5);
    endtask
    task automatic ev(input logic [37:0] v);
        {usb_event, dma_event, pipe_ack, pipe_nak} = v;
        cyc(1);
        {usb_event, dma_event, pipe_ack, pipe_nak} = 38'h0;
        cyc(3);
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard.
    initial begin
        #5000000;
        fail_count++;
        end_of_test;
    end
    // Main sequence.
    initial begin
        cyc(10);
        arst_n = 1'b1;
        cyc(2);
        chk({14'h0, suspend_ind, irq_pin}, 16'h0001);
        rd(`OFS_IRQ_CFG);
        chk(rd_data, 16'h0000);
        rd(8'h20);
        chk(rd_data, 16'h0000);
        wr(`OFS_IRQ_ENABLE, 16'h0020);
        ev({16'h0020, 22'h0});
        pin(1'b1);
        rd(`OFS_IRQ_STATUS);
        chk(rd_data, 16'h0020);
        wr(`OFS_MODE, 16'h0008);
        pin(1'b0);
        wr(`OFS_MODE, 16'h0000);
        pin(1'b0);
        wr(`OFS_IRQ_STATUS, 16'hFFFF);
        pin(1'b1);
        wr(`OFS_MODE, 16'h0008);
        ev({16'h0040, 22'h0});
        pin(1'b1);
        wr(`OFS_DMA_ENABLE, 16'h0001);
        ev({16'h0, 16'h0001, 6'h0});
        pin(1'b0);
        rd(`OFS_DMA_REASON);
        chk(rd_data, 16'h0001);
        wr(`OFS_DMA_REASON, 16'hFFFF);
        pin(1'b1);
        wr(`OFS_IRQ_STATUS, 16'hFFFF);
        wr(`OFS_IRQ_CFG, 16'h0003);
        act_hi = 1'b1;
        pin(1'b0);
        seen = irq_seen;
        usb_event = 16'h0020;
        cyc(1);
        usb_event = 16'h0000;
        hi_n = 0;
        repeat (8) begin
            cyc(1);
            hi_n += int'(irq_pin);
        end
        chk(16'(hi_n), 16'((60 + 49) / 50));
        chk(16'(irq_seen - seen), 16'h0001);
        pin(1'b0);
        for (int p = 0; p < 3; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(`OFS_IRQ_CFG, 16'(m << (6 - 2 * p)));
                ev({35'h0, 3'(1 << p)});
                rd(`OFS_IRQ_STATUS);
                chk({13'h0, rd_data[2:0]}, {13'h0, (m == 1 || m == 2) ? 3'(1 << p) : 3'h0});
                wr(`OFS_IRQ_STATUS, 16'hFFFF);
                ev({32'h0, 3'(1 << p), 3'h0});
                wr(`OFS_IRQ_STATUS, 16'hFFFF);
            end
        end
        // Level form with active-high polarity, then pulse form with active-low polarity.
        wr(`OFS_IRQ_CFG, 16'h0001);
        ev({16'h0020, 22'h0});
        pin(1'b1);
        wr(`OFS_IRQ_STATUS, 16'hFFFF);
        pin(1'b0);
        wr(`OFS_IRQ_CFG, 16'h0002);
        act_hi = 1'b0;
        pin(1'b1);
        seen = irq_seen;
        ev({16'h0020, 22'h0});
        chk(16'(irq_seen - seen), 16'h0001);
        pin(1'b1);
        // Reset in mid-run returns the pins and registers to their defaults.
        arst_n = 1'b0;
        cyc(2);
        chk({13'h0, data_oe, suspend_ind, irq_pin}, 16'h0001);
        arst_n = 1'b1;
        cyc(2);
        rd(`OFS_MODE);
        chk(rd_data, `MODE_RESET);
        rd(`OFS_IRQ_CFG);
        chk(rd_data, 16'h0000);
        end_of_test;
    end
endmodule
`default_nettype wire
